// ===== rtl/ssx_map.svh
`ifndef SSX_MAP_SVH
`define SSX_MAP_SVH
// Characters seen on the command line.
`define SSX_CH_CR    8'h0D
`define SSX_CH_SP    8'h20
`define SSX_CH_COMMA 8'h2C
`define SSX_CH_STORE 8'h73
`define SSX_CH_LEAVE 8'h78
`define SSX_CH_LO_N  8'h6E
`define SSX_CH_LO_I  8'h69
`define SSX_CH_UP_N  8'h4E
`define SSX_CH_UP_I  8'h49
`define SSX_CH_UP_Y  8'h59
`define SSX_CH_LO_Y  8'h79
// Wear limit of the nonvolatile store.
`define SSX_SAVE_LIMIT 16'h03E8
`define SSX_CNT_RST    16'h0000
`define SSX_CNT_ONE    16'h0001
// Hold time before leaving, and the clock rate.
`define SSX_HOLD_MS  3000
`define SSX_MCLK_KHZ 20000
`endif

// ===== rtl/ssx_pkg.sv
package ssx_pkg;
	// Messages handed to the text formatter.
	typedef enum logic [3:0] {
		SSX_M_NONE, SSX_M_SAVE_ASK, SSX_M_SAVE_OK,
		SSX_M_SAVE_COUNT, SSX_M_SAVE_ABORT, SSX_M_EXIT_ASK,
		SSX_M_TO_NORMAL, SSX_M_TO_INIT, SSX_M_E001,
		SSX_M_E002, SSX_M_E003, SSX_M_E004, SSX_M_E005,
		SSX_M_PROMPT
	} ssx_msg_t;
	typedef enum logic [3:0] {
		SSX_IDLE, SSX_STORE, SSX_LEAVE, SSX_TARGET,
		SSX_LEND, SSX_S_CONF, SSX_X_CONF, SSX_S_WAIT,
		SSX_HOLD, SSX_OUT, SSX_SKIP
	} ssx_state_t;
	typedef ssx_msg_t [3:0] ssx_queue_t;
endpackage : ssx_pkg

// ===== rtl/ssx_handler.sv
// Notes on behaviour
// - Confirmed store writes working configuration to nonvolatile memory.
// - Count completed stores; warn E004 once count exceeds 1000.
// - Always attempt the write on confirmation, whatever the count.
// - Store asks for confirmation; only upper-case Y proceeds.
// - Answer N reports abort; lower-case y reports abort and E003.
// - Successful store reports success, then the new store count.
// - Failed nonvolatile write reports E005.
// - Any character between store letter and CR gives E002.
// - Unknown command gives E001; out-of-range parameter gives E003.
// - Leave: wrong parameter count or comma after command gives E002.
// - Target n leaves to normal; asks upper-case Y if configuration differs.
// - Targets n and i hold 3 seconds after the response.
// - Target i leaves to init like n, reloading the stored configuration.
// - Targets N and I leave at once, no prompt, no hold.
// - Matching configuration leaves without prompt and announces the mode.
// - Leave confirmation N stays in service mode with a prompt.
// - Other leave confirmation answers give E003 and stay.
`timescale 1ns/1ps
`default_nettype none
`include "ssx_map.svh"
module ssx_handler #(
	parameter int unsigned HOLD_CYCLES = `SSX_HOLD_MS * `SSX_MCLK_KHZ
) (
	input  wire logic             mclk,
	input  wire logic             nrst,
	input  wire logic             rx_valid,
	input  wire logic [7:0]       rx_char,
	output logic                  rx_ready,
	input  wire logic             cfg_differs,
	input  wire logic             nvm_done,
	input  wire logic             nvm_fail,
	input  wire logic             svc_enter,
	output logic                  nvm_write,
	output logic                  resp_valid,
	output ssx_pkg::ssx_msg_t     resp_code,
	output logic [15:0]           save_count,
	output logic                  leave_normal,
	output logic                  leave_init,
	output logic                  reload_cfg
);
	localparam int HW = $clog2(HOLD_CYCLES + 1);
	localparam logic [HW-1:0] HOLD_LAST = HW'(HOLD_CYCLES - 1);

	// ----------------------------------------
	// Parser, message queue and store counter
	// ----------------------------------------
	ssx_pkg::ssx_state_t state_reg, state_next;
	ssx_pkg::ssx_queue_t q_reg, q_next;
	ssx_pkg::ssx_msg_t   err_reg, err_next;
	logic [15:0]         cnt_reg, cnt_next;
	logic [HW-1:0]       hold_reg, hold_next;
	logic                init_reg, init_next;
	logic                imm_reg, imm_next;
	logic                rdy_reg, rdy_next;
	logic                wr_reg, wr_next;
	logic                ln_reg, ln_next;
	logic                li_reg, li_next;
	logic                take;
	logic                save_yes;
	logic                save_lower;
	logic                done_ok;
	logic [15:0]         cnt_inc;

	assign take = rx_valid && rdy_reg;
	assign save_yes = take && state_reg == ssx_pkg::SSX_S_CONF
		&& rx_char == `SSX_CH_UP_Y;
	assign save_lower = take && state_reg == ssx_pkg::SSX_S_CONF
		&& rx_char == `SSX_CH_LO_Y;
	assign done_ok = state_reg == ssx_pkg::SSX_S_WAIT && nvm_done
		&& !nvm_fail;
	assign cnt_inc = cnt_reg + `SSX_CNT_ONE;

	// States that read a character; the queue must be drained first.
	function automatic logic ssx_listens(ssx_pkg::ssx_state_t s);
		return s inside {ssx_pkg::SSX_IDLE, ssx_pkg::SSX_STORE,
			ssx_pkg::SSX_LEAVE, ssx_pkg::SSX_TARGET,
			ssx_pkg::SSX_LEND, ssx_pkg::SSX_S_CONF,
			ssx_pkg::SSX_X_CONF, ssx_pkg::SSX_SKIP};
	endfunction : ssx_listens

	// Next-state logic; responses go out one message per cycle.
	always_comb begin
		state_next = state_reg;
		q_next     = q_reg;
		err_next   = err_reg;
		cnt_next   = cnt_reg;
		hold_next  = hold_reg;
		init_next  = init_reg;
		imm_next   = imm_reg;
		wr_next    = 1'b0;
		ln_next    = 1'b0;
		li_next    = 1'b0;
		if (q_reg[0] != ssx_pkg::SSX_M_NONE) begin
			q_next = '{ssx_pkg::SSX_M_NONE, q_reg[3], q_reg[2], q_reg[1]};
		end
		unique case (state_reg)
			ssx_pkg::SSX_IDLE: begin
				if (take) begin
					if (rx_char == `SSX_CH_STORE) begin
						state_next = ssx_pkg::SSX_STORE;
					end else if (rx_char == `SSX_CH_LEAVE) begin
						state_next = ssx_pkg::SSX_LEAVE;
					end else if (rx_char == `SSX_CH_CR) begin
						q_next[0] = ssx_pkg::SSX_M_PROMPT;
					end else begin
						err_next   = ssx_pkg::SSX_M_E001;
						state_next = ssx_pkg::SSX_SKIP;
					end
				end
			end
			ssx_pkg::SSX_STORE: begin
				if (take && rx_char == `SSX_CH_CR) begin
					q_next[0]  = ssx_pkg::SSX_M_SAVE_ASK;
					state_next = ssx_pkg::SSX_S_CONF;
				end else if (take) begin
					err_next   = ssx_pkg::SSX_M_E002;
					state_next = ssx_pkg::SSX_SKIP;
				end
			end
			ssx_pkg::SSX_LEAVE: begin
				if (take) begin
					unique case (rx_char)
						`SSX_CH_SP: state_next = ssx_pkg::SSX_TARGET;
						`SSX_CH_CR: begin
							q_next = '{ssx_pkg::SSX_M_NONE,
								ssx_pkg::SSX_M_NONE,
								ssx_pkg::SSX_M_PROMPT,
								ssx_pkg::SSX_M_E002};
							state_next = ssx_pkg::SSX_IDLE;
						end
						`SSX_CH_COMMA: begin
							err_next   = ssx_pkg::SSX_M_E002;
							state_next = ssx_pkg::SSX_SKIP;
						end
						default: begin
							err_next   = ssx_pkg::SSX_M_E001;
							state_next = ssx_pkg::SSX_SKIP;
						end
					endcase
				end
			end
			ssx_pkg::SSX_TARGET: begin
				if (take) begin
					init_next = rx_char == `SSX_CH_LO_I
						|| rx_char == `SSX_CH_UP_I;
					imm_next  = rx_char == `SSX_CH_UP_N
						|| rx_char == `SSX_CH_UP_I;
					state_next = ssx_pkg::SSX_SKIP;
					if (rx_char inside {`SSX_CH_LO_N, `SSX_CH_LO_I,
						`SSX_CH_UP_N, `SSX_CH_UP_I}) begin
						state_next = ssx_pkg::SSX_LEND;
					end else if (rx_char == `SSX_CH_CR) begin
						q_next = '{ssx_pkg::SSX_M_NONE,
							ssx_pkg::SSX_M_NONE,
							ssx_pkg::SSX_M_PROMPT,
							ssx_pkg::SSX_M_E002};
						state_next = ssx_pkg::SSX_IDLE;
					end else if (rx_char == `SSX_CH_COMMA) begin
						err_next = ssx_pkg::SSX_M_E002;
					end else begin
						err_next = ssx_pkg::SSX_M_E003;
					end
				end
			end
			ssx_pkg::SSX_LEND: begin
				if (take && rx_char != `SSX_CH_CR) begin
					err_next   = ssx_pkg::SSX_M_E002;
					state_next = ssx_pkg::SSX_SKIP;
				end else if (take && !imm_reg && cfg_differs) begin
					q_next[0]  = ssx_pkg::SSX_M_EXIT_ASK;
					state_next = ssx_pkg::SSX_X_CONF;
				end else if (take) begin
					q_next[0] = init_reg ? ssx_pkg::SSX_M_TO_INIT
						: ssx_pkg::SSX_M_TO_NORMAL;
					hold_next  = '0;
					state_next = ssx_pkg::SSX_HOLD;
				end
			end
			ssx_pkg::SSX_X_CONF: begin
				if (take && rx_char == `SSX_CH_UP_Y) begin
					q_next[0] = init_reg ? ssx_pkg::SSX_M_TO_INIT
						: ssx_pkg::SSX_M_TO_NORMAL;
					hold_next  = '0;
					state_next = ssx_pkg::SSX_HOLD;
				end else if (take && rx_char == `SSX_CH_UP_N) begin
					q_next[0]  = ssx_pkg::SSX_M_PROMPT;
					state_next = ssx_pkg::SSX_IDLE;
				end else if (take) begin
					q_next = '{ssx_pkg::SSX_M_NONE,
						ssx_pkg::SSX_M_NONE,
						ssx_pkg::SSX_M_PROMPT,
						ssx_pkg::SSX_M_E003};
					state_next = ssx_pkg::SSX_IDLE;
				end
			end
			ssx_pkg::SSX_S_CONF: begin
				if (take && rx_char == `SSX_CH_UP_Y) begin
					wr_next    = 1'b1;
					state_next = ssx_pkg::SSX_S_WAIT;
				end else if (take && rx_char == `SSX_CH_UP_N) begin
					q_next = '{ssx_pkg::SSX_M_NONE,
						ssx_pkg::SSX_M_NONE,
						ssx_pkg::SSX_M_PROMPT,
						ssx_pkg::SSX_M_SAVE_ABORT};
					state_next = ssx_pkg::SSX_IDLE;
				end else if (take) begin
					q_next = '{ssx_pkg::SSX_M_NONE,
						ssx_pkg::SSX_M_PROMPT,
						ssx_pkg::SSX_M_E003,
						ssx_pkg::SSX_M_SAVE_ABORT};
					state_next = ssx_pkg::SSX_IDLE;
				end
			end
			ssx_pkg::SSX_S_WAIT: begin
				if (nvm_done && nvm_fail) begin
					q_next = '{ssx_pkg::SSX_M_NONE,
						ssx_pkg::SSX_M_NONE,
						ssx_pkg::SSX_M_PROMPT,
						ssx_pkg::SSX_M_E005};
					state_next = ssx_pkg::SSX_IDLE;
				end else if (nvm_done) begin
					cnt_next = cnt_inc;
					q_next   = '{ssx_pkg::SSX_M_PROMPT,
						cnt_inc > `SSX_SAVE_LIMIT
							? ssx_pkg::SSX_M_E004
							: ssx_pkg::SSX_M_PROMPT,
						ssx_pkg::SSX_M_SAVE_COUNT,
						ssx_pkg::SSX_M_SAVE_OK};
					if (cnt_inc <= `SSX_SAVE_LIMIT) begin
						q_next[3] = ssx_pkg::SSX_M_NONE;
					end
					state_next = ssx_pkg::SSX_IDLE;
				end
			end
			ssx_pkg::SSX_HOLD: begin
				if (q_reg[0] == ssx_pkg::SSX_M_NONE) begin
					hold_next = hold_reg + HW'(1);
					if (imm_reg || hold_reg == HOLD_LAST) begin
						ln_next    = !init_reg;
						li_next    = init_reg;
						state_next = ssx_pkg::SSX_OUT;
					end
				end
			end
			ssx_pkg::SSX_OUT: begin
				if (svc_enter) begin
					state_next = ssx_pkg::SSX_IDLE;
				end
			end
			ssx_pkg::SSX_SKIP: begin
				if (take && rx_char == `SSX_CH_CR) begin
					q_next = '{ssx_pkg::SSX_M_NONE,
						ssx_pkg::SSX_M_NONE,
						ssx_pkg::SSX_M_PROMPT, err_reg};
					state_next = ssx_pkg::SSX_IDLE;
				end
			end
			default: state_next = ssx_pkg::SSX_IDLE;
		endcase
		rdy_next = ssx_listens(state_next)
			&& q_next[0] == ssx_pkg::SSX_M_NONE;
	end

	// Registers; a wide hold counter is cheaper than a prescaler chain.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= ssx_pkg::SSX_IDLE;
			q_reg     <= '{default: ssx_pkg::SSX_M_NONE};
			err_reg   <= ssx_pkg::SSX_M_NONE;
			cnt_reg   <= `SSX_CNT_RST;
			hold_reg  <= '0;
			init_reg  <= 1'b0;
			imm_reg   <= 1'b0;
			rdy_reg   <= 1'b0;
			wr_reg    <= 1'b0;
			ln_reg    <= 1'b0;
			li_reg    <= 1'b0;
		end else begin
			state_reg <= state_next;
			q_reg     <= q_next;
			err_reg   <= err_next;
			cnt_reg   <= cnt_next;
			hold_reg  <= hold_next;
			init_reg  <= init_next;
			imm_reg   <= imm_next;
			rdy_reg   <= rdy_next;
			wr_reg    <= wr_next;
			ln_reg    <= ln_next;
			li_reg    <= li_next;
		end
	end

	// Response outputs lag the queue head by one flop.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			resp_valid <= 1'b0;
			resp_code  <= ssx_pkg::SSX_M_NONE;
		end else begin
			resp_valid <= q_reg[0] != ssx_pkg::SSX_M_NONE;
			resp_code  <= q_reg[0];
		end
	end

	assign rx_ready     = rdy_reg;
	assign nvm_write    = wr_reg;
	assign save_count   = cnt_reg;
	assign leave_normal = ln_reg;
	assign leave_init   = li_reg;
	assign reload_cfg   = li_reg;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	a_write_needs_y: assert property (nvm_write |-> $past(save_yes))
		else $error("store write without upper-case Y");
	a_write_any_count: assert property (save_yes |=> nvm_write)
		else $error("confirmed store not attempted");
	a_write_once: assert property (nvm_write |=> !nvm_write)
		else $error("store write not a single pulse");
	a_count_step: assert property (done_ok |=> cnt_reg == $past(cnt_inc))
		else $error("store count did not advance");
	a_warn_limit: assert property (done_ok && cnt_inc > `SSX_SAVE_LIMIT
		|=> q_reg[2] == ssx_pkg::SSX_M_E004)
		else $error("wear warning missing");
	a_fail_report: assert property (state_reg == ssx_pkg::SSX_S_WAIT
		&& nvm_done && nvm_fail
		|=> q_reg[0] == ssx_pkg::SSX_M_E005 && $stable(cnt_reg))
		else $error("failed store not reported");
	a_lower_abort: assert property (save_lower
		|=> q_reg[0] == ssx_pkg::SSX_M_SAVE_ABORT
		&& q_reg[1] == ssx_pkg::SSX_M_E003)
		else $error("lower-case answer not refused");
	a_hold_time: assert property ((ln_reg || li_reg) && !imm_reg
		|-> $past(hold_reg) == HOLD_LAST)
		else $error("left before the hold time");
	a_init_reload: assert property (li_reg |-> reload_cfg && !ln_reg
		&& $past(state_reg) == ssx_pkg::SSX_HOLD && $past(init_reg))
		else $error("init leave without reload");

	c_store_ok: cover property (done_ok);
	c_leave_held: cover property (ln_reg && !imm_reg);
	c_leave_init_now: cover property (li_reg && imm_reg);
endmodule : ssx_handler
`default_nettype wire

// ===== sim/ssx_nvm_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Nonvolatile memory stand-in
// ----------------------------------------
module ssx_nvm_model #(
	parameter int unsigned LAT = 3
) (
	input  wire logic mclk,
	input  wire logic nrst,
	input  wire logic nvm_write,
	input  wire logic fail_mode,
	output logic      nvm_done,
	output logic      nvm_fail,
	output var int    n_writes
);
	int unsigned cnt;

	// The fail line toggles outside the done pulse, so a design that reads it
	// without the qualifier is caught.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cnt      <= 0;
			nvm_done <= 1'b0;
			nvm_fail <= 1'b0;
			n_writes <= 0;
		end else begin
			nvm_done <= 1'b0;
			nvm_fail <= ~nvm_fail;
			if (nvm_write) begin
				cnt      <= LAT;
				n_writes <= n_writes + 1;
			end else if (cnt == 1) begin
				cnt      <= 0;
				nvm_done <= 1'b1;
				nvm_fail <= fail_mode;
			end else if (cnt != 0) begin
				cnt <= cnt - 1;
			end
		end
	end
endmodule : ssx_nvm_model
`default_nettype wire

// ===== sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssx_map.svh"
module tb_top;
	localparam int HOLD = 20;
	logic              mclk        = 1'b0;
	logic              nrst        = 1'b0;
	logic              rx_valid    = 1'b0;
	logic [7:0]        rx_char     = 8'h00;
	logic              cfg_differs = 1'b0;
	logic              svc_enter   = 1'b0;
	logic              fail_mode   = 1'b0;
	logic              rx_ready, nvm_done, nvm_fail, nvm_write, resp_valid;
	logic              leave_normal, leave_init, reload_cfg, li;
	logic [15:0]       save_count;
	ssx_pkg::ssx_msg_t resp_code;
	ssx_pkg::ssx_msg_t got[$];
	int                n_writes, gap, gap_at, leaves, bad_count, n_compared;

	ssx_handler #(.HOLD_CYCLES(HOLD)) dut (.mclk(mclk), .nrst(nrst), .rx_valid(rx_valid),
		.rx_char(rx_char), .rx_ready(rx_ready), .cfg_differs(cfg_differs),
		.nvm_done(nvm_done), .nvm_fail(nvm_fail), .svc_enter(svc_enter),
		.nvm_write(nvm_write), .resp_valid(resp_valid), .resp_code(resp_code),
		.save_count(save_count), .leave_normal(leave_normal), .leave_init(leave_init),
		.reload_cfg(reload_cfg));
	ssx_nvm_model nvm (.mclk(mclk), .nrst(nrst), .nvm_write(nvm_write), .fail_mode(fail_mode),
		.nvm_done(nvm_done), .nvm_fail(nvm_fail), .n_writes(n_writes));

	// The 50 ns clock.
	initial begin
		forever #25 mclk = ~mclk;
	end

	// Messages are queued and the distance from the last one to a leave pulse is kept.
	always @(posedge mclk) begin
		if (resp_valid === 1'b1) got.push_back(resp_code);
		gap <= (resp_valid === 1'b1) ? 0 : gap + 1;
		if (leave_normal === 1'b1 || leave_init === 1'b1) begin
			leaves <= leaves + 1;
			gap_at <= gap;
			li     <= leave_init & reload_cfg;
		end
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic complete_run();
		$display("Compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : complete_run

	task automatic hung();
		bad_count++;
		complete_run();
	endtask : hung

	task automatic cmp_val(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("FAIL at %0t: got %h expected %h", $time, g, e);
		end
	endtask : cmp_val

	// Waits a bounded time for the next message, since a lost one would hang.
	task automatic cmp_msg(input ssx_pkg::ssx_msg_t e);
		int k;
		k = 0;
		while (got.size() == 0 && k < 200) begin
			@(posedge mclk);
			k++;
		end
		// A message that lands on the last allowed edge still counts as arrived.
		if (got.size() == 0) hung();
		cmp_val(32'(got.pop_front()), 32'(e));
	endtask : cmp_msg

	// The char is held until an edge that sees rx_ready high.
	task automatic send(input logic [7:0] c);
		int k;
		logic r;
		rx_valid <= 1'b1;
		rx_char  <= c;
		k = 0;
		r = 1'b0;
		while (r !== 1'b1 && k < 200) begin
			@(negedge mclk);
			r = rx_ready;
			@(posedge mclk);
			k++;
		end
		if (r !== 1'b1) hung();
	endtask : send

	task automatic send_str(input string s);
		for (int i = 0; i < s.len(); i++) send(s[i]);
		rx_valid <= 1'b0;
	endtask : send_str

	task automatic ask_store(input string a);
		send_str("s\015");
		cmp_msg(ssx_pkg::SSX_M_SAVE_ASK);
		send_str(a);
	endtask : ask_store

	task automatic leave_chk(input ssx_pkg::ssx_msg_t e, input logic init, input logic hold);
		int k;
		int n0;
		n0 = leaves;
		cmp_msg(e);
		k = 0;
		while (leaves == n0 && k < HOLD + 50) begin
			@(posedge mclk);
			k++;
		end
		if (leaves == n0) hung();
		cmp_val(32'(li), 32'(init));
		// The gap counter starts one edge after the message, so one is added back.
		cmp_val(32'(hold ? (gap_at + 1 >= HOLD && gap_at + 1 <= HOLD + 3) : (gap_at < 4)), 1);
		cmp_val(32'(rx_ready), 0);
		svc_enter <= 1'b1;
		@(posedge mclk);
		svc_enter <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask : leave_chk

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_syntax();
		string c [6] = '{"sa\015", "q\015", "x\015", "x,n\015", "x q\015", "x nn\015"};
		ssx_pkg::ssx_msg_t e [6] = '{ssx_pkg::SSX_M_E002, ssx_pkg::SSX_M_E001,
			ssx_pkg::SSX_M_E002, ssx_pkg::SSX_M_E002, ssx_pkg::SSX_M_E003, ssx_pkg::SSX_M_E002};
		for (int i = 0; i < 6; i++) begin
			send_str(c[i]);
			cmp_msg(e[i]);
			cmp_msg(ssx_pkg::SSX_M_PROMPT);
		end
		send_str("\015");
		cmp_msg(ssx_pkg::SSX_M_PROMPT);
	endtask : t_syntax

	task automatic t_refuse();
		ask_store("N");
		cmp_msg(ssx_pkg::SSX_M_SAVE_ABORT);
		cmp_msg(ssx_pkg::SSX_M_PROMPT);
		ask_store("y");
		cmp_msg(ssx_pkg::SSX_M_SAVE_ABORT);
		cmp_msg(ssx_pkg::SSX_M_E003);
		cmp_msg(ssx_pkg::SSX_M_PROMPT);
		cmp_val(n_writes, 0);
	endtask : t_refuse

	// The warning must first appear on the store that takes the count past the limit.
	task automatic t_wear();
		for (int i = 1; i <= 1001; i++) begin
			ask_store("Y");
			cmp_msg(ssx_pkg::SSX_M_SAVE_OK);
			cmp_msg(ssx_pkg::SSX_M_SAVE_COUNT);
			if (i > 1000) cmp_msg(ssx_pkg::SSX_M_E004);
			cmp_msg(ssx_pkg::SSX_M_PROMPT);
			cmp_val(32'(save_count), i);
			cmp_val(n_writes, i);
		end
	endtask : t_wear

	task automatic t_fail();
		fail_mode <= 1'b1;
		ask_store("Y");
		cmp_msg(ssx_pkg::SSX_M_E005);
		cmp_msg(ssx_pkg::SSX_M_PROMPT);
		cmp_val(n_writes, 1002);
		cmp_val(32'(save_count), 1001);
		fail_mode <= 1'b0;
	endtask : t_fail

	task automatic t_leave_ask();
		cfg_differs <= 1'b1;
		send_str("x n\015");
		cmp_msg(ssx_pkg::SSX_M_EXIT_ASK);
		send_str("N");
		cmp_msg(ssx_pkg::SSX_M_PROMPT);
		send_str("x i\015");
		cmp_msg(ssx_pkg::SSX_M_EXIT_ASK);
		send_str("q");
		cmp_msg(ssx_pkg::SSX_M_E003);
		cmp_msg(ssx_pkg::SSX_M_PROMPT);
		send_str("x n\015");
		cmp_msg(ssx_pkg::SSX_M_EXIT_ASK);
		send_str("Y");
		leave_chk(ssx_pkg::SSX_M_TO_NORMAL, 1'b0, 1'b1);
	endtask : t_leave_ask

	task automatic t_leave(input logic [7:0] tc, input logic d, input ssx_pkg::ssx_msg_t e,
		input logic init, input logic hold);
		cfg_differs <= d;
		send(`SSX_CH_LEAVE);
		send(`SSX_CH_SP);
		send(tc);
		send(`SSX_CH_CR);
		rx_valid <= 1'b0;
		leave_chk(e, init, hold);
	endtask : t_leave

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (6) @(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
		t_syntax();
		t_refuse();
		t_wear();
		t_fail();
		t_leave_ask();
		t_leave(`SSX_CH_LO_I, 1'b0, ssx_pkg::SSX_M_TO_INIT, 1'b1, 1'b1);
		t_leave(`SSX_CH_LO_N, 1'b0, ssx_pkg::SSX_M_TO_NORMAL, 1'b0, 1'b1);
		t_leave(`SSX_CH_UP_N, 1'b1, ssx_pkg::SSX_M_TO_NORMAL, 1'b0, 1'b0);
		t_leave(`SSX_CH_UP_I, 1'b1, ssx_pkg::SSX_M_TO_INIT, 1'b1, 1'b0);
		complete_run();
	end
endmodule : tb_top
`default_nettype wire
